// [hdl/mks_scanner.sv]
`timescale 1ns/1ps
`default_nettype none
module mks_scanner
	import mks_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        execEnable,
	input  wire logic        interlock,
	input  wire logic        destFault,
	input  wire logic [7:0]  returnLineWord,
	output logic      [8:0]  selectLineWord,
	output logic             scanBusyFlag,
	output logic             faultFlag,
	output logic             irq,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata
);
	import mks_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers: pins are asynchronous to clk_sys
	logic [7:0] retMeta_reg;
	logic [7:0] retSync_reg;
	logic [2:0] ctlMeta_reg;
	logic [2:0] ctlSync_reg;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			retMeta_reg <= 8'h00;
			retSync_reg <= 8'h00;
			ctlMeta_reg <= 3'h0;
			ctlSync_reg <= 3'h0;
		end
		else
		begin
			retMeta_reg <= returnLineWord;
			retSync_reg <= retMeta_reg;
			ctlMeta_reg <= {destFault, interlock, execEnable};
			ctlSync_reg <= ctlMeta_reg;
		end
	end

	wire enSync   = ctlSync_reg[0];
	wire lockSync = ctlSync_reg[1];
	wire faultIn  = ctlSync_reg[2];
	wire runNow   = enSync && !lockSync;

	////////////////////////////////////////////////////////////////////////
	// Phase sequencer
	mks_state_e state_reg;
	mks_state_e state_next;
	logic [3:0] phase_reg;
	logic [3:0] phase_next;
	logic [1:0] tick_reg;
	logic [1:0] tick_next;

	wire lastTick  = (tick_reg == 2'(MKS_CYCLES_PER_PHASE - 1));
	wire lastPhase = (phase_reg == MKS_DONE_PHASE);
	// Sample on last cycle of a row so the matrix has settled
	wire doSample  = runNow && state_reg == MKS_SCAN && lastTick
		&& !lastPhase;
	wire roundDone = runNow && state_reg == MKS_SCAN && lastTick
		&& lastPhase;

	always_comb
	begin
		state_next = state_reg;
		phase_next = phase_reg;
		tick_next  = tick_reg;
		unique case (state_reg)
			MKS_IDLE:
			begin
				if (runNow)
				begin
					state_next = MKS_SCAN;
					phase_next = 4'h0;
					tick_next  = 2'h0;
				end
			end
			MKS_SCAN:
			begin
				if (!runNow)
					state_next = state_reg;
				else if (!lastTick)
					tick_next = tick_reg + 2'h1;
				else
				begin
					tick_next  = 2'h0;
					phase_next = lastPhase ? 4'h0 : phase_reg + 4'h1;
				end
			end
			default:
				state_next = MKS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_reg <= MKS_IDLE;
			phase_reg <= 4'h0;
			tick_reg  <= 2'h0;
		end
		else
		begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			tick_reg  <= tick_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs: one-hot select word, held when execEnable drops, cleared to zero by interlock
	logic [8:0] select_reg;
	logic [8:0] select_next;
	logic       busy_reg;
	logic       fault_reg;

	always_comb
	begin
		select_next = select_reg;
		if (runNow && state_next == MKS_SCAN)
			select_next = 9'h001 << phase_next;
		else if (lockSync)
			select_next = 9'h000;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			select_reg <= 9'h000;
			busy_reg   <= 1'b0;
			fault_reg  <= 1'b0;
		end
		else
		begin
			select_reg <= select_next;
			busy_reg   <= runNow;
			fault_reg  <= runNow && faultIn;
		end
	end

	assign selectLineWord = select_reg;
	assign scanBusyFlag   = busy_reg;
	assign faultFlag      = fault_reg;

	////////////////////////////////////////////////////////////////////////
	// Key storage
	mks_row_if rowBus ();
	logic [63:0] keyBits;

	// Fault blocks the write: destination is invalid
	assign rowBus.sample = doSample && !faultIn;
	assign rowBus.row    = phase_reg[2:0];
	assign rowBus.lines  = retSync_reg;

	mks_key_store u_store (
		.clk_sys (clk_sys),
		.reset   (reset),
		.rowBus  (rowBus.store),
		.keyBits (keyBits)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over write-one-clear
	logic [1:0] irqStat_reg;
	logic [1:0] irqMask_reg;
	logic       irq_reg;
	logic [15:0] rdata_reg;

	wire [1:0] irqEvents = {runNow && faultIn, roundDone};
	wire wrStat = regWr && regAddr == ADDR_IRQ_STAT;
	wire wrMask = regWr && regAddr == ADDR_IRQ_MASK;
	wire [1:0] statClr = wrStat ? regWdata[1:0] : 2'h0;
	wire [1:0] statNext = (irqStat_reg & ~statClr) | irqEvents;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			irqStat_reg <= IRQ_RESET;
			irqMask_reg <= IRQ_RESET;
			irq_reg     <= 1'b0;
		end
		else
		begin
			irqStat_reg <= statNext;
			if (wrMask)
				irqMask_reg <= regWdata[1:0];
			irq_reg <= |(statNext & (wrMask ? regWdata[1:0] : irqMask_reg));
		end
	end

	assign irq = irq_reg;

	////////////////////////////////////////////////////////////////////////
	// Register read port, data one cycle after strobe
	logic [15:0] rdMux;

	always_comb
	begin
		unique case (regAddr)
			ADDR_KEY0:     rdMux = keyBits[15:0];
			ADDR_KEY1:     rdMux = keyBits[31:16];
			ADDR_KEY2:     rdMux = keyBits[47:32];
			ADDR_KEY3:     rdMux = keyBits[63:48];
			ADDR_STATUS:   rdMux = {13'h0000, select_reg[8], fault_reg, busy_reg};
			ADDR_IRQ_STAT: rdMux = {14'h0000, irqStat_reg};
			ADDR_IRQ_MASK: rdMux = {14'h0000, irqMask_reg};
			default:       rdMux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rdata_reg <= KEY_RESET;
		else
			rdata_reg <= regRd ? rdMux : 16'h0000;
	end

	assign regRdata = rdata_reg;
endmodule : mks_scanner
`default_nettype wire

// [inc/mks_pkg.sv]
package mks_pkg;
	localparam int MKS_ROWS = 8;
	localparam int MKS_COLS = 8;
	localparam int MKS_CYCLES_PER_PHASE = 3;
	localparam int MKS_PHASES = 9;
	localparam logic [3:0] MKS_DONE_PHASE = 4'h8;
	localparam logic [3:0] ADDR_KEY0 = 4'h0;
	localparam logic [3:0] ADDR_KEY1 = 4'h1;
	localparam logic [3:0] ADDR_KEY2 = 4'h2;
	localparam logic [3:0] ADDR_KEY3 = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
	localparam int IRQ_ROUND = 0;
	localparam int IRQ_FAULT = 1;
	localparam logic [15:0] KEY_RESET = 16'h0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	typedef enum logic [1:0]
	{
		MKS_IDLE = 2'b00,
		MKS_SCAN = 2'b01
	} mks_state_e;
endpackage : mks_pkg

// [inc/mks_row_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mks_row_if;
	logic       sample;
	logic [2:0] row;
	logic [7:0] lines;
	logic [7:0] rowBits;
	modport ctrl (output sample, output row, output lines, input rowBits);
	modport store (input sample, input row, input lines, output rowBits);
endinterface : mks_row_if
`default_nettype wire

// [hdl/mks_key_store.sv]
`timescale 1ns/1ps
`default_nettype none
module mks_key_store
	import mks_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  reset,
	mks_row_if.store   rowBus,
	output logic [63:0] keyBits
);
	logic [63:0] keys_reg;

	assign keyBits = keys_reg;
	assign rowBus.rowBits = keys_reg[rowBus.row*8 +: 8];

	genvar r;
	generate
		for (r = 0; r < MKS_ROWS; r++)
		begin : g_row
			always_ff @(posedge clk_sys)
			begin
				if (reset)
					keys_reg[r*8 +: 8] <= 8'h00;
				else if (rowBus.sample && rowBus.row == 3'(r))
					keys_reg[r*8 +: 8] <= rowBus.lines;
			end
		end
	endgenerate
endmodule : mks_key_store
`default_nettype wire

// [bench/mks_key_matrix.sv]
`timescale 1ns/1ps
`default_nettype none
module mks_key_matrix
(
	input  wire logic [63:0] pressed,
	input  wire logic [8:0]  selectLineWord,
	output logic      [7:0]  returnLineWord
);
	// Open switches read low; selected rows wire-OR onto the returns
	// Returns follow the select word at once, refreshed every cycle
	always_comb
	begin
		returnLineWord = 8'h00;
		for (int r = 0; r < 8; r++)
			if (selectLineWord[r])
				returnLineWord |= pressed[r*8 +: 8];
	end
endmodule : mks_key_matrix
`default_nettype wire

// [bench/mks_scanner_props.sv]
`timescale 1ns/1ps
`default_nettype none
module mks_scanner_props
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [8:0] selectLineWord,
	input  wire logic       scanBusyFlag,
	input  wire logic       faultFlag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_select_onehot: assert property ($onehot0(selectLineWord))
		else $error("select not one-hot");
	chk_row_order: assert property (selectLineWord != 9'h000 &&
		$past(selectLineWord) != 9'h000 && $changed(selectLineWord) |->
		$past(selectLineWord) == {selectLineWord[0], selectLineWord[8:1]})
		else $error("select out of order");
	chk_phase_min: assert property ($changed(selectLineWord) &&
		selectLineWord != 9'h000 && $past(scanBusyFlag, 3) |->
		$past(selectLineWord, 3) == $past(selectLineWord))
		else $error("select phase too short");
	chk_phase_max: assert property (scanBusyFlag[*4] |->
		selectLineWord != $past(selectLineWord, 3))
		else $error("select phase too long");
	chk_idle_frozen: assert property (!scanBusyFlag |->
		$stable(selectLineWord) || selectLineWord == 9'h000)
		else $error("select moved while idle");
	chk_done_three: assert property ($fell(selectLineWord[8]) &&
		selectLineWord[0] && $past(scanBusyFlag, 3) |->
		$past(selectLineWord[8], 3))
		else $error("round mark too short");
	chk_fault_busy: assert property (faultFlag |-> scanBusyFlag)
		else $error("fault while not running");
	chk_reset_quiet: assert property (disable iff (1'b0) reset |=>
		selectLineWord == 9'h000 && !scanBusyFlag && !faultFlag)
		else $error("outputs active after reset");
endmodule : mks_scanner_props
`default_nettype wire

// [bench/mks_scanner_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mks_scanner_tb;
	import mks_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        execEnable = 1'b0;
	logic        interlock = 1'b0;
	logic        destFault = 1'b0;
	logic [7:0]  returnLineWord;
	logic [8:0]  selectLineWord;
	logic        scanBusyFlag, faultFlag, irq, regWr = 1'b0, regRd = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000, regRdata;
	logic [63:0] pressed = '0;
	int          miscompares = 0, checks_done = 0;
	int unsigned keyModel [4] = '{default: 0};
	always #25 clk_sys = ~clk_sys;
	// Single scanner instance only
	mks_scanner i_dut (.clk_sys(clk_sys), .reset(reset),
		.execEnable(execEnable), .interlock(interlock), .destFault(destFault),
		.returnLineWord(returnLineWord), .selectLineWord(selectLineWord),
		.scanBusyFlag(scanBusyFlag), .faultFlag(faultFlag), .irq(irq),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata));
	mks_key_matrix i_keys (.pressed(pressed),
		.selectLineWord(selectLineWord), .returnLineWord(returnLineWord));
	////////////////////////////////////////////////////////////////////////
	task automatic cmpVal(input string name, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : cmpVal
	task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wrReg
	task automatic rdReg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 cmpVal("register", exp, regRdata);
	endtask : rdReg
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hbe54));
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		for (int a = 0; a < 16; a++)
			rdReg(4'(a), 16'h0000);
		@(posedge clk_sys);
		execEnable <= 1'b1;
		// Last pattern releases every key
		for (int n = 0; n < 6; n++)
		begin
			@(posedge clk_sys);
			pressed <= (n == 5) ? '0 : {$urandom, $urandom};
			destFault <= (n == 4);
			repeat (60) @(posedge clk_sys);
			for (int w = 0; w < 4; w++)
				if (n != 4)
					keyModel[w] = pressed[16*w +: 16];
			for (int w = 0; w < 4; w++)
				rdReg(4'(w), 16'(keyModel[w]));
			cmpVal("fault", 16'(n == 4), 16'(faultFlag));
		end
		@(posedge clk_sys);
		execEnable <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 cmpVal("busy", 16'h0000, 16'(scanBusyFlag));
		wrReg(ADDR_KEY0, 16'hffff);
		rdReg(ADDR_KEY0, 16'(keyModel[0]));
		rdReg(ADDR_IRQ_STAT, 16'h0003);
		cmpVal("irq", 16'h0000, 16'(irq));
		wrReg(ADDR_IRQ_MASK, 16'h0002);
		rdReg(ADDR_IRQ_MASK, 16'h0002);
		cmpVal("irq", 16'h0001, 16'(irq));
		wrReg(ADDR_IRQ_STAT, 16'h0002);
		rdReg(ADDR_IRQ_STAT, 16'h0001);
		cmpVal("irq", 16'h0000, 16'(irq));
		@(posedge clk_sys);
		execEnable <= 1'b1;
		interlock <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1 cmpVal("select", 16'h0000, {7'h00, selectLineWord});
		cmpVal("busy", 16'h0000, 16'(scanBusyFlag));
		@(posedge clk_sys);
		interlock <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1 cmpVal("busy", 16'h0001, 16'(scanBusyFlag));
		results();
	end
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		miscompares++;
		results();
	end
endmodule : mks_scanner_tb
bind mks_scanner mks_scanner_props i_props (.clk_sys(clk_sys), .reset(reset),
	.selectLineWord(selectLineWord), .scanBusyFlag(scanBusyFlag),
	.faultFlag(faultFlag));
`default_nettype wire
